//--- rtl/pin_cell_array.sv
// Overview of operation
// - The pin cells hold no storage; registering happens in fabric flip-flops.
// - Input path has one delay stage, inserted by default, skipped per cell.
// - Output value goes straight to the pad, optionally inverted.
// - High float control floats the pad; low drives the output value.
// - Output and float polarities are chosen independently per cell.
// - Outputs use slow slew unless the per-cell fast option is set.
// - First output activation after configuration is slow on every pin.
// - Global float floats all outputs except during boundary-scan EXTEST.
// - Global float comes from a pin, optionally inverted, or an internal node.
// - Pull-ups are enabled on cells while configuration is in progress.
// - After configuration unused pads default to their pull-up.
// - Unused pads may instead use pull-down, drive, or be externally driven.
//
// array of pin cells with apb configuration and start-up sequencing
// assumes pad inputs and the global float pin are asynchronous to CLK
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module pin_cell_array
    import pin_cell_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [DATA_W-1:0] PWDATA,
    output logic [DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [CELL_COUNT-1:0] PAD_IN,
    output logic [CELL_COUNT-1:0] PAD_O,
    output logic [CELL_COUNT-1:0] PAD_OE,
    output logic [CELL_COUNT-1:0] PAD_FAST,
    output logic [CELL_COUNT-1:0] PAD_PULLUP,
    output logic [CELL_COUNT-1:0] PAD_PULLDOWN,
    input wire logic [CELL_COUNT-1:0] USER_OUT,
    input wire logic [CELL_COUNT-1:0] USER_FLOAT,
    output logic [CELL_COUNT-1:0] USER_IN,
    input wire logic GFLOAT_PIN,
    input wire logic GFLOAT_NODE,
    input wire logic EXTEST_ACTIVE,
    output logic STARTUP_DONE
);

    // ****************************************
    // declarations
    // ****************************************
    startup_state_t state;
    startup_state_t next_state;
    logic [SOFT_CNT_W-1:0] soft_cnt;
    logic [CELL_COUNT-1:0] skip_input_delay;
    logic [CELL_COUNT-1:0] out_inv;
    logic [CELL_COUNT-1:0] float_inv;
    logic [CELL_COUNT-1:0] fast;
    logic [CELL_COUNT-1:0] used;
    logic [CELL_COUNT*MODE_W-1:0] unused_mode;
    logic [GCFG_W-1:0] gfloat_cfg;
    logic [CELL_COUNT-1:0] pad_sync1;
    logic [CELL_COUNT-1:0] pad_sync2;
    logic [CELL_COUNT-1:0] pad_delayed;
    logic [CELL_COUNT-1:0] fabric_in;
    logic gpin_sync1;
    logic gpin_sync2;
    logic gfloat_src;
    logic global_output_float;
    logic config_busy;
    logic soft_slow;
    logic wr_en;
    logic rd_setup;
    logic cfg_wr;
    logic [DATA_W-1:0] next_rdata;
    logic next_err;
    logic err_q;

    // ****************************************
    // apb handshake and strobes
    // ****************************************
    assign PREADY = CE;
    assign PSLVERR = err_q & PSEL & PENABLE;
    assign wr_en = CE & PSEL & PENABLE & PWRITE;
    assign rd_setup = CE & PSEL & ~PENABLE;
    assign cfg_wr = wr_en & (state == ST_CONFIG);

    // ****************************************
    // read mux and unmapped address detection
    // ****************************************
    always_comb begin
        next_rdata = '0;
        next_err = 1'b0;
        if (PADDR == OFS_CTRL) begin
            next_rdata[CTRL_START_BIT] = (state != ST_CONFIG);
        end else if (PADDR == OFS_STATUS) begin
            next_rdata[STATUS_STATE_LSB +: STATE_W] = state;
            next_rdata[STATUS_GFLOAT_BIT] = global_output_float;
            next_rdata[STATUS_EXTEST_BIT] = EXTEST_ACTIVE;
        end else if (PADDR == OFS_SKIP_DELAY) begin
            next_rdata[CELL_COUNT-1:0] = skip_input_delay;
        end else if (PADDR == OFS_OUT_INV) begin
            next_rdata[CELL_COUNT-1:0] = out_inv;
        end else if (PADDR == OFS_FLOAT_INV) begin
            next_rdata[CELL_COUNT-1:0] = float_inv;
        end else if (PADDR == OFS_FAST) begin
            next_rdata[CELL_COUNT-1:0] = fast;
        end else if (PADDR == OFS_USED) begin
            next_rdata[CELL_COUNT-1:0] = used;
        end else if (PADDR == OFS_UNUSED_MODE) begin
            next_rdata[CELL_COUNT*MODE_W-1:0] = unused_mode;
        end else if (PADDR == OFS_GFLOAT_CFG) begin
            next_rdata[GCFG_W-1:0] = gfloat_cfg;
        end else if (PADDR == OFS_IN_STATE) begin
            next_rdata[CELL_COUNT-1:0] = USER_IN;
        end else begin
            next_err = 1'b1;
        end
    end

    // ****************************************
    // read data and error capture in setup phase
    // ****************************************
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            PRDATA <= '0;
            err_q <= 1'b0;
        end else if (rd_setup) begin
            PRDATA <= PWRITE ? '0 : next_rdata;
            err_q <= next_err;
        end
    end

    // ****************************************
    // configuration registers, frozen after start-up
    // ****************************************
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            skip_input_delay <= RST_SKIP_DELAY;
            out_inv <= RST_OUT_INV;
            float_inv <= RST_FLOAT_INV;
            fast <= RST_FAST;
            used <= RST_USED;
            unused_mode <= RST_UNUSED_MODE;
            gfloat_cfg <= RST_GFLOAT_CFG;
        end else if (cfg_wr) begin
            if (PADDR == OFS_SKIP_DELAY) begin
                skip_input_delay <= PWDATA[CELL_COUNT-1:0];
            end else if (PADDR == OFS_OUT_INV) begin
                out_inv <= PWDATA[CELL_COUNT-1:0];
            end else if (PADDR == OFS_FLOAT_INV) begin
                float_inv <= PWDATA[CELL_COUNT-1:0];
            end else if (PADDR == OFS_FAST) begin
                fast <= PWDATA[CELL_COUNT-1:0];
            end else if (PADDR == OFS_USED) begin
                used <= PWDATA[CELL_COUNT-1:0];
            end else if (PADDR == OFS_UNUSED_MODE) begin
                unused_mode <= PWDATA[CELL_COUNT*MODE_W-1:0];
            end else if (PADDR == OFS_GFLOAT_CFG) begin
                gfloat_cfg <= PWDATA[GCFG_W-1:0];
            end
        end
    end

    // ****************************************
    // start-up sequence
    // ****************************************
    always_comb begin
        next_state = state;
        case (state)
            ST_CONFIG: begin
                if (wr_en && PADDR == OFS_CTRL && PWDATA[CTRL_START_BIT]) begin
                    next_state = ST_SOFT_START;
                end
            end
            ST_SOFT_START: begin
                if (soft_cnt == SOFT_CNT_W'(SOFT_START_CYCLES - 1)) begin
                    next_state = ST_USER;
                end
            end
            ST_USER: next_state = ST_USER;
            default: next_state = ST_CONFIG;
        endcase
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state <= ST_CONFIG;
        end else if (CE) begin
            state <= next_state;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            soft_cnt <= '0;
        end else if (CE) begin
            if (state == ST_SOFT_START) begin
                soft_cnt <= soft_cnt + SOFT_CNT_W'(1);
            end else begin
                soft_cnt <= '0;
            end
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            STARTUP_DONE <= 1'b0;
        end else if (CE) begin
            STARTUP_DONE <= (next_state == ST_USER);
        end
    end

    assign config_busy = (state == ST_CONFIG);
    assign soft_slow = (state != ST_USER);

    // ****************************************
    // fabric input flip-flops and delay stage
    // ****************************************
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pad_sync1 <= '0;
            pad_sync2 <= '0;
            pad_delayed <= '0;
        end else if (CE) begin
            pad_sync1 <= PAD_IN;
            pad_sync2 <= pad_sync1;
            pad_delayed <= pad_sync2;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            USER_IN <= '0;
        end else if (CE) begin
            USER_IN <= fabric_in;
        end
    end

    // ****************************************
    // global output float source
    // ****************************************
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            gpin_sync1 <= 1'b0;
            gpin_sync2 <= 1'b0;
        end else if (CE) begin
            gpin_sync1 <= GFLOAT_PIN;
            gpin_sync2 <= gpin_sync1;
        end
    end

    always_comb begin
        if (gfloat_cfg[GCFG_SRC_PIN_BIT]) begin
            gfloat_src = gpin_sync2 ^ gfloat_cfg[GCFG_INVERT_BIT];
        end else begin
            gfloat_src = GFLOAT_NODE;
        end
    end

    assign global_output_float = gfloat_src & ~EXTEST_ACTIVE;

    // ****************************************
    // combinational pin cells
    // ****************************************
    pin_cell u_cells (
        .pad_in_direct(pad_sync2),
        .pad_in_delayed(pad_delayed),
        .skip_input_delay(skip_input_delay),
        .out_value(USER_OUT),
        .float_ctl(USER_FLOAT),
        .out_inv(out_inv),
        .float_inv(float_inv),
        .fast(fast),
        .used(used),
        .unused_mode(unused_mode),
        .global_output_float(global_output_float),
        .soft_slow(soft_slow),
        .config_busy(config_busy),
        .fabric_in(fabric_in),
        .pad_o(PAD_O),
        .pad_oe(PAD_OE),
        .pad_fast(PAD_FAST),
        .pad_pullup(PAD_PULLUP),
        .pad_pulldown(PAD_PULLDOWN)
    );

endmodule : pin_cell_array

//--- shared/pin_cell_pkg.sv
// constants, field layouts and state codes for the pin cell array
// assumes a 200 MHz system clock and a 32-bit apb register bus
package pin_cell_pkg;

    // ****************************************
    // array size and bus widths
    // ****************************************
    localparam int CELL_COUNT = 8;
    localparam int MODE_W = 2;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_SKIP_DELAY = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_OUT_INV = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_FLOAT_INV = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_FAST = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_USED = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_UNUSED_MODE = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_GFLOAT_CFG = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_IN_STATE = 8'h24;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CTRL_START_BIT = 0;
    localparam int GCFG_SRC_PIN_BIT = 0;
    localparam int GCFG_INVERT_BIT = 1;
    localparam int GCFG_W = 2;
    localparam int STATUS_STATE_LSB = 0;
    localparam int STATUS_GFLOAT_BIT = 3;
    localparam int STATUS_EXTEST_BIT = 4;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [CELL_COUNT-1:0] RST_SKIP_DELAY = 8'h00;
    localparam logic [CELL_COUNT-1:0] RST_OUT_INV = 8'h00;
    localparam logic [CELL_COUNT-1:0] RST_FLOAT_INV = 8'h00;
    localparam logic [CELL_COUNT-1:0] RST_FAST = 8'h00;
    localparam logic [CELL_COUNT-1:0] RST_USED = 8'h00;
    localparam logic [CELL_COUNT*MODE_W-1:0] RST_UNUSED_MODE = 16'h0000;
    localparam logic [GCFG_W-1:0] RST_GFLOAT_CFG = 2'h0;

    // ****************************************
    // unused pad treatment
    // ****************************************
    typedef enum logic [MODE_W-1:0] {
        UNUSED_PULLUP = 2'h0,
        UNUSED_PULLDOWN = 2'h1,
        UNUSED_DRIVEN = 2'h2,
        UNUSED_EXTERNAL = 2'h3
    } unused_mode_t;

    // ****************************************
    // start-up sequence states
    // ****************************************
    localparam int STATE_W = 3;
    typedef enum logic [STATE_W-1:0] {
        ST_CONFIG = 3'h1,
        ST_SOFT_START = 3'h2,
        ST_USER = 3'h4
    } startup_state_t;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SOFT_START_NS = 100;
    localparam int SOFT_START_CYCLES = (SOFT_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SOFT_CNT_W = 6;

endpackage : pin_cell_pkg

//--- rtl/pin_cell.sv
// purely combinational pin cells, one per package pin
// assumes all options come from static configuration state outside
`timescale 1ns/1ps
module pin_cell
    import pin_cell_pkg::*;
(
    input wire logic [CELL_COUNT-1:0] pad_in_direct,
    input wire logic [CELL_COUNT-1:0] pad_in_delayed,
    input wire logic [CELL_COUNT-1:0] skip_input_delay,
    input wire logic [CELL_COUNT-1:0] out_value,
    input wire logic [CELL_COUNT-1:0] float_ctl,
    input wire logic [CELL_COUNT-1:0] out_inv,
    input wire logic [CELL_COUNT-1:0] float_inv,
    input wire logic [CELL_COUNT-1:0] fast,
    input wire logic [CELL_COUNT-1:0] used,
    input wire logic [CELL_COUNT*MODE_W-1:0] unused_mode,
    input wire logic global_output_float,
    input wire logic soft_slow,
    input wire logic config_busy,
    output logic [CELL_COUNT-1:0] fabric_in,
    output logic [CELL_COUNT-1:0] pad_o,
    output logic [CELL_COUNT-1:0] pad_oe,
    output logic [CELL_COUNT-1:0] pad_fast,
    output logic [CELL_COUNT-1:0] pad_pullup,
    output logic [CELL_COUNT-1:0] pad_pulldown
);

    // ****************************************
    // per-cell datapath, no storage
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < CELL_COUNT; g++) begin : g_cell
            unused_mode_t mode;
            logic data;
            logic float_req;
            assign mode = unused_mode_t'(unused_mode[g*MODE_W +: MODE_W]);
            assign fabric_in[g] = skip_input_delay[g] ? pad_in_direct[g] : pad_in_delayed[g];
            assign data = out_value[g] ^ out_inv[g];
            assign float_req = float_ctl[g] ^ float_inv[g];
            assign pad_fast[g] = fast[g] & ~soft_slow;

            always_comb begin
                pad_o[g] = data;
                pad_oe[g] = 1'b0;
                pad_pullup[g] = 1'b0;
                pad_pulldown[g] = 1'b0;
                if (config_busy) begin
                    pad_pullup[g] = 1'b1;
                end else if (used[g]) begin
                    pad_oe[g] = ~float_req & ~global_output_float;
                end else begin
                    case (mode)
                        UNUSED_PULLUP: pad_pullup[g] = 1'b1;
                        UNUSED_PULLDOWN: pad_pulldown[g] = 1'b1;
                        UNUSED_DRIVEN: begin
                            pad_o[g] = 1'b0;
                            pad_oe[g] = ~global_output_float;
                        end
                        default: pad_pullup[g] = 1'b0;
                    endcase
                end
            end
        end
    endgenerate

endmodule : pin_cell

//--- tb/pad_board_model.sv
// board side of the pads: resolves each pad level from all drivers
// assumes the bench supplies external driver values and enables
`timescale 1ns/1ps
module pad_board_model
    import pin_cell_pkg::*;
(
    input wire logic [CELL_COUNT-1:0] pad_o,
    input wire logic [CELL_COUNT-1:0] pad_oe,
    input wire logic [CELL_COUNT-1:0] pad_pullup,
    input wire logic [CELL_COUNT-1:0] pad_pulldown,
    input wire logic [CELL_COUNT-1:0] board_drive,
    input wire logic [CELL_COUNT-1:0] board_en,
    output logic [CELL_COUNT-1:0] pad_level
);
    // ****
    // pad level resolution
    // ****
    always_comb begin
        for (int i = 0; i < CELL_COUNT; i++) begin
            if (pad_oe[i]) begin
                pad_level[i] = pad_o[i];
            end else if (board_en[i]) begin
                pad_level[i] = board_drive[i];
            end else if (pad_pullup[i]) begin
                pad_level[i] = 1'b1;
            end else if (pad_pulldown[i]) begin
                pad_level[i] = 1'b0;
            end else begin
                // floating pad shows the inverse of the cell value
                pad_level[i] = ~pad_o[i];
            end
        end
    end
endmodule : pad_board_model

//--- tb/pin_cell_array_asserts.sv
// port assertions for the pin cell array
// assumes CE stays high and options are written only before start-up
`timescale 1ns/1ps
module pin_cell_array_asserts
    import pin_cell_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [DATA_W-1:0] PWDATA,
    input wire logic [CELL_COUNT-1:0] PAD_O,
    input wire logic [CELL_COUNT-1:0] PAD_OE,
    input wire logic [CELL_COUNT-1:0] PAD_FAST,
    input wire logic [CELL_COUNT-1:0] PAD_PULLUP,
    input wire logic [CELL_COUNT-1:0] PAD_PULLDOWN,
    input wire logic [CELL_COUNT-1:0] USER_OUT,
    input wire logic [CELL_COUNT-1:0] USER_FLOAT,
    input wire logic GFLOAT_PIN,
    input wire logic GFLOAT_NODE,
    input wire logic EXTEST_ACTIVE,
    input wire logic STARTUP_DONE
);
    // ****
    // shadow of the static options
    // ****
    logic cfg_phase;
    logic wr;
    logic [CELL_COUNT-1:0] used, oinv, finv, fast;
    logic [GCFG_W-1:0] gcfg;
    assign wr = PSEL && PENABLE && PWRITE && CE && cfg_phase;
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cfg_phase <= 1'b1;
            used <= RST_USED;
            oinv <= RST_OUT_INV;
            finv <= RST_FLOAT_INV;
            fast <= RST_FAST;
            gcfg <= RST_GFLOAT_CFG;
        end else if (wr) begin
            if (PADDR == OFS_CTRL && PWDATA[CTRL_START_BIT]) cfg_phase <= 1'b0;
            if (PADDR == OFS_USED) used <= PWDATA[CELL_COUNT-1:0];
            if (PADDR == OFS_OUT_INV) oinv <= PWDATA[CELL_COUNT-1:0];
            if (PADDR == OFS_FLOAT_INV) finv <= PWDATA[CELL_COUNT-1:0];
            if (PADDR == OFS_FAST) fast <= PWDATA[CELL_COUNT-1:0];
            if (PADDR == OFS_GFLOAT_CFG) gcfg <= PWDATA[GCFG_W-1:0];
        end
    end
    // ****
    // assertions
    // ****
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    property p_cfg_quiet;
        cfg_phase |-> PAD_OE == '0 && PAD_PULLUP == '1 && PAD_PULLDOWN == '0;
    endproperty
    a_cfg_quiet: assert property (p_cfg_quiet) else $error("pad active in configuration");
    property p_soft_slow;
        !STARTUP_DONE |-> PAD_FAST == '0;
    endproperty
    a_soft_slow: assert property (p_soft_slow) else $error("fast slew before start-up end");
    property p_start_len;
        wr && PADDR == OFS_CTRL && PWDATA[CTRL_START_BIT]
            |=> (!STARTUP_DONE) [*8] ##12 !STARTUP_DONE ##1 STARTUP_DONE;
    endproperty
    a_start_len: assert property (p_start_len) else $error("soft start length wrong");
    property p_fast;
        STARTUP_DONE |-> PAD_FAST == fast;
    endproperty
    a_fast: assert property (p_fast) else $error("slew select wrong");
    property p_out;
        STARTUP_DONE |-> (PAD_O & used) == ((USER_OUT ^ oinv) & used);
    endproperty
    a_out: assert property (p_out) else $error("pad value wrong");
    property p_extest;
        STARTUP_DONE && EXTEST_ACTIVE |-> (PAD_OE & used) == (~(USER_FLOAT ^ finv) & used);
    endproperty
    a_extest: assert property (p_extest) else $error("enable wrong in extest");
    property p_gnode;
        STARTUP_DONE && !gcfg[GCFG_SRC_PIN_BIT] && GFLOAT_NODE && !EXTEST_ACTIVE |-> PAD_OE == '0;
    endproperty
    a_gnode: assert property (p_gnode) else $error("global float ignored");
    property p_gpin;
        STARTUP_DONE && gcfg[GCFG_SRC_PIN_BIT] && !EXTEST_ACTIVE && ($past(GFLOAT_PIN, 2) ^ gcfg[GCFG_INVERT_BIT])
            |-> PAD_OE == '0;
    endproperty
    a_gpin: assert property (p_gpin) else $error("pin global float ignored");
    property p_pull_excl;
        (PAD_PULLUP & PAD_PULLDOWN) == '0 && (PAD_OE & (PAD_PULLUP | PAD_PULLDOWN)) == '0;
    endproperty
    a_pull_excl: assert property (p_pull_excl) else $error("pull clash");
endmodule : pin_cell_array_asserts

bind pin_cell_array pin_cell_array_asserts u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .CE(CE), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PAD_O(PAD_O), .PAD_OE(PAD_OE),
    .PAD_FAST(PAD_FAST), .PAD_PULLUP(PAD_PULLUP), .PAD_PULLDOWN(PAD_PULLDOWN), .USER_OUT(USER_OUT),
    .USER_FLOAT(USER_FLOAT), .GFLOAT_PIN(GFLOAT_PIN), .GFLOAT_NODE(GFLOAT_NODE),
    .EXTEST_ACTIVE(EXTEST_ACTIVE), .STARTUP_DONE(STARTUP_DONE));

//--- tb/io_cell_control_bench.sv
// self-checking bench for the pin cell array
// assumes zero wait state apb and a board model on the pads
`timescale 1ns/1ps
module io_cell_control_bench;
    import pin_cell_pkg::*;
    logic CLK = 0, SYS_RST = 1, CE = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, err;
    logic GFLOAT_PIN = 0, GFLOAT_NODE = 0, EXTEST_ACTIVE = 0, STARTUP_DONE;
    logic [ADDR_W-1:0] PADDR = '0;
    logic [DATA_W-1:0] PWDATA = '0, PRDATA, rd;
    logic [CELL_COUNT-1:0] PAD_IN, PAD_O, PAD_OE, PAD_FAST, PAD_PULLUP, PAD_PULLDOWN, USER_IN;
    logic [CELL_COUNT-1:0] USER_OUT = '0, USER_FLOAT = '0, bd = '0, be = '0;
    int n_mismatch = 0, checks = 0, n;
    typedef struct {logic [7:0] uo, uf; logic node, ext; logic [7:0] o, oe;} row_t;
    row_t rows[6] = '{'{8'h00, 8'h00, 1'b0, 1'b0, 8'h50, 8'hF4}, '{8'hFF, 8'hFF, 1'b0, 1'b0, 8'hA0, 8'h04},
        '{8'hA5, 8'h30, 1'b0, 1'b0, 8'hF0, 8'hC4}, '{8'h00, 8'h00, 1'b1, 1'b0, 8'h50, 8'h00},
        '{8'hFF, 8'h00, 1'b1, 1'b1, 8'hA0, 8'hF4}, '{8'h00, 8'h90, 1'b0, 1'b0, 8'h50, 8'h64}};
    always #2.5 CLK = ~CLK;
    pin_cell_array u_dut (.CLK(CLK), .SYS_RST(SYS_RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .PAD_IN(PAD_IN), .PAD_O(PAD_O), .PAD_OE(PAD_OE), .PAD_FAST(PAD_FAST), .PAD_PULLUP(PAD_PULLUP),
        .PAD_PULLDOWN(PAD_PULLDOWN), .USER_OUT(USER_OUT), .USER_FLOAT(USER_FLOAT), .USER_IN(USER_IN),
        .GFLOAT_PIN(GFLOAT_PIN), .GFLOAT_NODE(GFLOAT_NODE), .EXTEST_ACTIVE(EXTEST_ACTIVE),
        .STARTUP_DONE(STARTUP_DONE));
    pad_board_model u_board (.pad_o(PAD_O), .pad_oe(PAD_OE), .pad_pullup(PAD_PULLUP),
        .pad_pulldown(PAD_PULLDOWN), .board_drive(bd), .board_en(be), .pad_level(PAD_IN));
    // ****
    // shared tasks
    // ****
    task automatic wrap_up();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int i;
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge CLK);
            if (PREADY) break;
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (i == 16) begin
            n_mismatch++;
            wrap_up();
        end
    endtask : apb
    task automatic configure(input logic [7:0] used, input logic [7:0] skip, input logic [1:0] gcfg);
        apb(1, OFS_OUT_INV, 32'h55);
        apb(1, OFS_FLOAT_INV, 32'h0F);
        apb(1, OFS_FAST, 32'h33);
        apb(1, OFS_USED, {24'h0, used});
        apb(1, OFS_UNUSED_MODE, 32'hE4);
        apb(1, OFS_SKIP_DELAY, {24'h0, skip});
        apb(1, OFS_GFLOAT_CFG, {30'h0, gcfg});
        apb(1, OFS_CTRL, 32'h1);
        for (n = 1; n <= 40; n++) begin
            @(posedge CLK);
            #1;
            if (n == 5) check(PAD_FAST, 8'h00);
            if (STARTUP_DONE) break;
        end
        check(n, SOFT_START_CYCLES);
        check(PAD_FAST, 8'h33);
    endtask : configure
    task automatic do_reset();
        SYS_RST <= 1'b1;
        repeat (16) @(posedge CLK);
        SYS_RST <= 1'b0;
        #1;
        check(PAD_PULLUP, 8'hFF);
        check(PAD_OE, 8'h00);
    endtask : do_reset
    // ****
    // main sequence
    // ****
    initial begin
        do_reset();
        apb(0, OFS_UNUSED_MODE, 0);
        check(rd, 0);
        apb(0, OFS_SKIP_DELAY, 0);
        check(rd, 0);
        apb(0, 8'hFC, 0);
        check(err, 1'b1);
        configure(8'hF0, 8'h30, 2'h0);
        apb(0, OFS_STATUS, 0);
        check(rd, 32'h4);
        for (int i = 0; i < 6; i++) begin
            @(posedge CLK);
            USER_OUT <= rows[i].uo;
            USER_FLOAT <= rows[i].uf;
            GFLOAT_NODE <= rows[i].node;
            EXTEST_ACTIVE <= rows[i].ext;
            @(posedge CLK);
            #1;
            check(PAD_O & 8'hF4, rows[i].o);
            check(PAD_OE, rows[i].oe);
            check(PAD_PULLUP, 8'h01);
            check(PAD_PULLDOWN, 8'h02);
        end
        apb(1, OFS_OUT_INV, 0);
        apb(0, OFS_OUT_INV, 0);
        check(rd, 32'h55);
        check(PAD_O & 8'hF4, 8'h50);
        // used pads floated, board holds them low, then high
        @(posedge CLK);
        USER_FLOAT <= 8'hFF;
        be <= 8'hF0;
        repeat (5) @(posedge CLK);
        bd <= 8'hF0;
        repeat (3) @(posedge CLK);
        #1;
        check(USER_IN[7:4], 4'h3);
        @(posedge CLK);
        #1;
        check(USER_IN[7:4], 4'hF);
        apb(0, OFS_IN_STATE, 0);
        check(rd, 32'hF9);
        // clock enable low freezes the input flops
        @(posedge CLK);
        CE <= 1'b0;
        bd <= 8'h00;
        repeat (6) @(posedge CLK);
        #1;
        check(USER_IN, 8'hF9);
        @(posedge CLK);
        CE <= 1'b1;
        // second reset, global float from an inverted pin
        @(posedge CLK);
        do_reset();
        configure(8'hFF, 8'hFF, 2'h3);
        @(posedge CLK);
        USER_FLOAT <= 8'h00;
        GFLOAT_NODE <= 1'b1;
        EXTEST_ACTIVE <= 1'b0;
        GFLOAT_PIN <= 1'b1;
        repeat (3) @(posedge CLK);
        #1;
        check(PAD_OE, 8'hF0);
        @(posedge CLK);
        GFLOAT_PIN <= 1'b0;
        repeat (3) @(posedge CLK);
        #1;
        check(PAD_OE, 8'h00);
        wrap_up();
    end
endmodule : io_cell_control_bench
